/* File: src/tmw_pkg.sv */
package tmw_pkg;
  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [2:0] CLK_SEL_STOP = 3'h0;
  localparam logic WAVE_RST = 1'b0;

  typedef enum logic [1:0] {
    TMW_MODE_NORMAL = 2'h0,
    TMW_MODE_PHASE = 2'h1,
    TMW_MODE_CTC = 2'h2,
    TMW_MODE_FAST = 2'h3
  } tmw_mode_t;

  typedef enum logic [1:0] {
    TMW_ACT_OFF = 2'h0,
    TMW_ACT_TOGGLE = 2'h1,
    TMW_ACT_CLEAR = 2'h2,
    TMW_ACT_SET = 2'h3
  } tmw_action_t;

  // one-hot sequencing of the counter
  typedef enum logic [1:0] {
    TMW_DIR_UP = 2'h1,
    TMW_DIR_DOWN = 2'h2
  } tmw_dir_t;
endpackage

/* File: src/tmw_flag.sv */
module tmw_flag (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else if (clk_en) begin
      if (set) begin
        flag <= 1'b1;
      end else if (clear) begin
        flag <= 1'b0;
      end
    end
  end
endmodule

/* File: src/tmw_timer.sv */
// Behaviour
// - normal mode only counts up, wraps to zero
// - normal overflow set as counter becomes zero
// - clear-on-compare clears counter at compare match
// - clear-on-compare compare value written unbuffered
// - clear-on-compare match raises compare flag
// - clear-on-compare action one toggles output
// - clear-on-compare overflow set at max to zero
// - pin driven only when direction selects output
// - fast mode counts zero to max, clears
// - fast actions two/three clear/set output
// - fast opposite transition at max to zero
// - fast overflow set as counter goes from max to zero
// - fast extremes: spike at zero, constant at max
// - fast action one toggles, buffering still active
// - dual-slope holds max one cycle, reverses
// - dual-slope turns at fixed max only
// - dual-slope actions depend on count direction
// - dual-slope overflow set when counter reaches zero
// - dual-slope extremes hold output constant
// - leaving max, top takes up-count result
// - missed up-count match still applied at top
// - compare flag set one tick after match
// - pwm compare value updates only on the tick leaving max (top)
// - counter write blocks next tick's match
// - clock selection zero stops the counter
module tmw_timer (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic timer_tick,
  input wire logic [2:0] clock_selection,
  input wire logic [1:0] waveform_mode_select,
  input wire logic [1:0] output_action_select,
  input wire logic counter_wr,
  input wire logic [7:0] counter_wr_data,
  input wire logic compare_wr,
  input wire logic [7:0] compare_wr_data,
  input wire logic force_compare,
  input wire logic overflow_clear,
  input wire logic compare_match_clear,
  input wire logic pin_dir_out,
  output logic [7:0] counter_value,
  output logic [7:0] compare_value,
  output logic [7:0] compare_buffer,
  output logic count_down,
  output logic overflow_flag,
  output logic compare_match_flag,
  output logic wave_output,
  output logic pin_out,
  output logic pin_oe
);
  tmw_pkg::tmw_mode_t mode;
  tmw_pkg::tmw_action_t action;
  tmw_pkg::tmw_dir_t dir;
  tmw_pkg::tmw_dir_t next_dir;
  logic tick;
  logic pwm_mode;
  logic at_max;
  logic at_bottom;
  logic match_raw;
  logic match_ok;
  logic block_match;
  logic ovf_set;
  logic buf_load;
  logic [7:0] next_counter;
  logic [7:0] next_compare;
  logic next_wave;
  logic up_level;

  assign mode = tmw_pkg::tmw_mode_t'(waveform_mode_select);
  assign action = tmw_pkg::tmw_action_t'(output_action_select);
  assign pwm_mode = (mode == tmw_pkg::TMW_MODE_PHASE) || (mode == tmw_pkg::TMW_MODE_FAST);
  // a stopped clock source simply never ticks
  assign tick = clk_en && timer_tick && (clock_selection != tmw_pkg::CLK_SEL_STOP);
  assign at_max = (counter_value == tmw_pkg::CNT_MAX);
  assign at_bottom = (counter_value == tmw_pkg::CNT_BOTTOM);
  assign match_raw = (counter_value == compare_value);
  assign match_ok = tick && match_raw && !block_match;
  assign count_down = (dir == tmw_pkg::TMW_DIR_DOWN);

  // counter sequencing per mode
  always_comb begin
    next_counter = counter_value;
    next_dir = dir;
    case (mode)
      tmw_pkg::TMW_MODE_NORMAL: begin
        next_counter = counter_value + tmw_pkg::CNT_ONE;
        next_dir = tmw_pkg::TMW_DIR_UP;
      end
      tmw_pkg::TMW_MODE_CTC: begin
        // a compare value below the count is missed until the wrap
        // a match blocked by a counter write does not clear either
        if (match_raw && !block_match) begin
          next_counter = tmw_pkg::CNT_BOTTOM;
        end else begin
          next_counter = counter_value + tmw_pkg::CNT_ONE;
        end
        next_dir = tmw_pkg::TMW_DIR_UP;
      end
      tmw_pkg::TMW_MODE_FAST: begin
        if (at_max) begin
          next_counter = tmw_pkg::CNT_BOTTOM;
        end else begin
          next_counter = counter_value + tmw_pkg::CNT_ONE;
        end
        next_dir = tmw_pkg::TMW_DIR_UP;
      end
      tmw_pkg::TMW_MODE_PHASE: begin
        // turnaround is fixed at max, never at the compare value
        if (dir == tmw_pkg::TMW_DIR_UP) begin
          if (at_max) begin
            next_counter = counter_value - tmw_pkg::CNT_ONE;
            next_dir = tmw_pkg::TMW_DIR_DOWN;
          end else begin
            next_counter = counter_value + tmw_pkg::CNT_ONE;
          end
        end else begin
          if (at_bottom) begin
            next_counter = counter_value + tmw_pkg::CNT_ONE;
            next_dir = tmw_pkg::TMW_DIR_UP;
          end else begin
            next_counter = counter_value - tmw_pkg::CNT_ONE;
          end
        end
      end
      default: begin
        next_counter = counter_value;
        next_dir = dir;
      end
    endcase
  end

  // a software write has priority over any count or clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      counter_value <= tmw_pkg::CNT_RST;
    end else if (clk_en) begin
      if (counter_wr) begin
        counter_value <= counter_wr_data;
      end else if (tick) begin
        counter_value <= next_counter;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dir <= tmw_pkg::TMW_DIR_UP;
    end else if (clk_en) begin
      if (mode != tmw_pkg::TMW_MODE_PHASE) begin
        dir <= tmw_pkg::TMW_DIR_UP;
      end else if (tick && !counter_wr) begin
        dir <= next_dir;
      end
    end
  end

  // match blocking lasts until the next tick, even while stopped
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      block_match <= 1'b0;
    end else if (clk_en) begin
      if (counter_wr) begin
        block_match <= 1'b1;
      end else if (tick) begin
        block_match <= 1'b0;
      end
    end
  end

  // compare buffer: direct in non-pwm modes, synchronised in pwm modes
  assign buf_load = tick && !counter_wr && at_max &&
    ((mode == tmw_pkg::TMW_MODE_FAST) ||
     ((mode == tmw_pkg::TMW_MODE_PHASE) && (dir == tmw_pkg::TMW_DIR_UP)));

  always_comb begin
    next_compare = compare_value;
    if (!pwm_mode) begin
      if (compare_wr) begin
        next_compare = compare_wr_data;
      end
    end else if (buf_load) begin
      next_compare = compare_buffer;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      compare_buffer <= tmw_pkg::CMP_RST;
    end else if (clk_en && compare_wr) begin
      compare_buffer <= compare_wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      compare_value <= tmw_pkg::CMP_RST;
    end else if (clk_en) begin
      compare_value <= next_compare;
    end
  end

  // overflow events
  always_comb begin
    ovf_set = 1'b0;
    if (tick && !counter_wr) begin
      if (mode == tmw_pkg::TMW_MODE_PHASE) begin
        ovf_set = count_down && (counter_value == tmw_pkg::CNT_ONE);
      end else begin
        ovf_set = at_max;
      end
    end
  end

  tmw_flag u_overflow (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .set(ovf_set),
    .clear(overflow_clear),
    .flag(overflow_flag)
  );

  // flag lands on the edge after the tick that saw the match
  tmw_flag u_compare (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .set(match_ok),
    .clear(compare_match_clear),
    .flag(compare_match_flag)
  );

  // level left by an up-counting match in dual-slope mode
  assign up_level = (action == tmw_pkg::TMW_ACT_SET);

  always_comb begin
    next_wave = wave_output;
    case (mode)
      tmw_pkg::TMW_MODE_NORMAL, tmw_pkg::TMW_MODE_CTC: begin
        // forcing acts like a match but sets no flag and clears nothing
        if (match_ok || force_compare) begin
          case (action)
            tmw_pkg::TMW_ACT_TOGGLE: next_wave = !wave_output;
            tmw_pkg::TMW_ACT_CLEAR: next_wave = 1'b0;
            tmw_pkg::TMW_ACT_SET: next_wave = 1'b1;
            default: next_wave = wave_output;
          endcase
        end
      end
      tmw_pkg::TMW_MODE_FAST: begin
        if (action == tmw_pkg::TMW_ACT_TOGGLE) begin
          if (match_ok) begin
            next_wave = !wave_output;
          end
        end else if (action != tmw_pkg::TMW_ACT_OFF) begin
          // bottom wins so a compare value at max gives a steady level
          if (tick && at_max) begin
            next_wave = (action == tmw_pkg::TMW_ACT_CLEAR);
          end else if (match_ok) begin
            next_wave = (action == tmw_pkg::TMW_ACT_SET);
          end
        end
      end
      tmw_pkg::TMW_MODE_PHASE: begin
        if (action[1]) begin
          if (tick && !counter_wr && at_max && (dir == tmw_pkg::TMW_DIR_UP) &&
              (next_compare != tmw_pkg::CNT_MAX)) begin
            next_wave = up_level;
          end else if (match_ok) begin
            // direction after this tick decides the slope of the match
            if (next_dir == tmw_pkg::TMW_DIR_UP) begin
              next_wave = up_level;
            end else begin
              next_wave = !up_level;
            end
          end
        end
      end
      default: next_wave = wave_output;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wave_output <= tmw_pkg::WAVE_RST;
    end else if (clk_en) begin
      wave_output <= next_wave;
    end
  end

  // pin value always follows the wave state; it is enabled only when connected and set to output
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (clk_en) begin
      pin_out <= next_wave;
      pin_oe <= pin_dir_out && (action != tmw_pkg::TMW_ACT_OFF);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  chk_normal_wrap: assert property (
    (tick && !counter_wr && mode == tmw_pkg::TMW_MODE_NORMAL && at_max)
      |=> (counter_value == 8'h00) && overflow_flag)
    else $error("normal mode did not wrap to zero with overflow");

  chk_ctc_clear: assert property (
    (tick && !counter_wr && !block_match && mode == tmw_pkg::TMW_MODE_CTC && match_raw)
      |=> counter_value == 8'h00)
    else $error("clear-on-compare did not clear the counter");

  chk_match_flag: assert property (
    match_ok |=> compare_match_flag)
    else $error("compare flag not set after match");

  chk_write_block: assert property (
    (block_match && tick && !compare_match_flag) |=> !compare_match_flag)
    else $error("match after counter write was not blocked");

  chk_stop_hold: assert property (
    (clk_en && clock_selection == 3'h0 && !counter_wr) |=> $stable(counter_value))
    else $error("counter moved while stopped");

  chk_phase_top: assert property (
    (tick && !counter_wr && mode == tmw_pkg::TMW_MODE_PHASE && at_max && !count_down)
      |=> count_down && (counter_value == 8'hFE))
    else $error("dual-slope did not turn at max");

  chk_phase_ovf: assert property (
    (tick && !counter_wr && mode == tmw_pkg::TMW_MODE_PHASE && count_down &&
     counter_value == 8'h01) |=> overflow_flag)
    else $error("dual-slope overflow missing at bottom");

  chk_pin_gate: assert property (
    (clk_en && !pin_dir_out) |=> !pin_oe)
    else $error("pin driven while direction is input");

  chk_fast_clear: assert property (
    (match_ok && mode == tmw_pkg::TMW_MODE_FAST && action == tmw_pkg::TMW_ACT_CLEAR &&
     !at_max) |=> !wave_output)
    else $error("fast pwm output not cleared on match");

  cov_ctc_match: cover property (
    tick && mode == tmw_pkg::TMW_MODE_CTC && match_ok);
  cov_phase_turn: cover property (
    tick && mode == tmw_pkg::TMW_MODE_PHASE && at_max ##1 count_down);
  cov_fast_bottom: cover property (
    tick && mode == tmw_pkg::TMW_MODE_FAST && at_max && action == tmw_pkg::TMW_ACT_CLEAR);
endmodule

/* File: tb/test_timer8_waveform_modes.sv */
module test_timer8_waveform_modes;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic timer_tick = 1'b0;
  logic [2:0] clock_selection = 3'h1;
  logic [1:0] waveform_mode_select = 2'h0;
  logic [1:0] output_action_select = 2'h0;
  logic counter_wr = 1'b0;
  logic [7:0] counter_wr_data = 8'h00;
  logic compare_wr = 1'b0;
  logic [7:0] compare_wr_data = 8'h00;
  logic flag_clr = 1'b0;
  logic pin_dir_out = 1'b1;
  logic clk_en = 1'b1;
  logic force_compare = 1'b0;
  logic [7:0] counter_value, compare_value, compare_buffer;
  logic count_down, overflow_flag, compare_match_flag, wave_output, pin_out, pin_oe;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;

  tmw_timer u_dut (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .timer_tick(timer_tick),
    .clock_selection(clock_selection),
    .waveform_mode_select(waveform_mode_select),
    .output_action_select(output_action_select),
    .counter_wr(counter_wr),
    .counter_wr_data(counter_wr_data),
    .compare_wr(compare_wr),
    .compare_wr_data(compare_wr_data),
    .force_compare(force_compare),
    .overflow_clear(flag_clr),
    .compare_match_clear(flag_clr),
    .pin_dir_out(pin_dir_out),
    .counter_value(counter_value),
    .compare_value(compare_value),
    .compare_buffer(compare_buffer),
    .count_down(count_down),
    .overflow_flag(overflow_flag),
    .compare_match_flag(compare_match_flag),
    .wave_output(wave_output),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // whole run needs about 1100 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk1(input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // tick held as a level for n edges; #1 lets the last edge land
  task automatic tick_n(input int n);
    @(posedge clk_sys);
    timer_tick <= 1'b1;
    repeat (n) @(posedge clk_sys);
    timer_tick <= 1'b0;
    #1;
  endtask

  task automatic wr_cnt(input logic [7:0] d);
    @(posedge clk_sys);
    counter_wr <= 1'b1;
    counter_wr_data <= d;
    @(posedge clk_sys);
    counter_wr <= 1'b0;
    #1;
  endtask

  task automatic wr_cmp(input logic [7:0] d);
    @(posedge clk_sys);
    compare_wr <= 1'b1;
    compare_wr_data <= d;
    @(posedge clk_sys);
    compare_wr <= 1'b0;
    #1;
  endtask

  task automatic clr();
    @(posedge clk_sys);
    flag_clr <= 1'b1;
    @(posedge clk_sys);
    flag_clr <= 1'b0;
    #1;
  endtask

  task automatic cfg(input logic [1:0] m, input logic [1:0] a, input logic [2:0] cs);
    @(posedge clk_sys);
    waveform_mode_select <= m;
    output_action_select <= a;
    clock_selection <= cs;
  endtask

  task automatic t_normal();
    cfg(2'h0, 2'h0, 3'h1);
    wr_cnt(8'hFE);
    tick_n(1);
    chk8(8'hFF, counter_value);
    chk1(1'b0, overflow_flag);
    tick_n(1);
    chk8(tmw_pkg::CNT_BOTTOM, counter_value);
    chk1(1'b1, overflow_flag);
    tick_n(1);
    chk1(1'b1, overflow_flag);
    chk1(1'b0, pin_oe);
    cfg(2'h0, 2'h0, tmw_pkg::CLK_SEL_STOP);
    tick_n(3);
    chk8(8'h01, counter_value);
  endtask

  task automatic t_ctc();
    cfg(2'h2, 2'h1, 3'h1);
    wr_cmp(8'h03);
    chk8(8'h03, compare_value);
    wr_cnt(8'h00);
    clr();
    tick_n(3);
    chk8(8'h03, counter_value);
    chk1(1'b0, compare_match_flag);
    tick_n(1);
    chk8(8'h00, counter_value);
    chk1(1'b1, compare_match_flag);
    chk1(1'b1, wave_output);
    chk1(1'b1, pin_out);
    chk1(1'b1, pin_oe);
    tick_n(4);
    chk1(1'b0, wave_output);
  endtask

  // writing the count equal to the compare value loses that match
  task automatic t_block();
    clr();
    wr_cnt(8'h03);
    tick_n(1);
    chk8(8'h04, counter_value);
    chk1(1'b0, compare_match_flag);
    tick_n(251);
    chk8(8'hFF, counter_value);
    chk1(1'b0, overflow_flag);
    tick_n(1);
    chk8(8'h00, counter_value);
    chk1(1'b1, overflow_flag);
  endtask

  task automatic t_fast();
    cfg(2'h3, 2'h2, 3'h1);
    wr_cmp(8'h80);
    chk8(8'h03, compare_value);
    chk8(8'h80, compare_buffer);
    wr_cnt(8'hFE);
    clr();
    tick_n(2);
    chk8(8'h00, counter_value);
    chk1(1'b1, overflow_flag);
    chk8(8'h80, compare_value);
    chk1(1'b1, wave_output);
    tick_n(8'h80);
    chk1(1'b1, wave_output);
    tick_n(1);
    chk1(1'b0, wave_output);
    chk1(1'b1, compare_match_flag);
    cfg(2'h3, 2'h3, 3'h1);
    tick_n(127);
    chk8(8'h00, counter_value);
    chk1(1'b0, wave_output);
    tick_n(8'h81);
    chk1(1'b1, wave_output);
  endtask

  task automatic t_dual();
    cfg(2'h1, 2'h2, 3'h1);
    wr_cnt(8'hFD);
    clr();
    tick_n(2);
    chk8(8'hFF, counter_value);
    chk1(1'b0, count_down);
    tick_n(1);
    chk8(8'hFE, counter_value);
    chk1(1'b1, count_down);
    chk1(1'b0, wave_output);
    tick_n(253);
    chk8(8'h01, counter_value);
    chk1(1'b0, overflow_flag);
    chk1(1'b1, wave_output);
    tick_n(1);
    chk8(8'h00, counter_value);
    chk1(1'b1, overflow_flag);
    tick_n(1);
    chk8(8'h01, counter_value);
    chk1(1'b0, count_down);
    @(posedge clk_sys);
    pin_dir_out <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk1(1'b0, pin_oe);
  endtask

  task automatic frc();
    @(posedge clk_sys);
    force_compare <= 1'b1;
    @(posedge clk_sys);
    force_compare <= 1'b0;
    #1;
  endtask

  // counter writes jump to the turnaround points to keep the run short
  task automatic t_dual_ext();
    clr();
    wr_cmp(8'h00);
    wr_cnt(8'hFE);
    tick_n(2);
    chk8(8'h00, compare_value);
    chk1(1'b0, wave_output);
    wr_cnt(8'h01);
    tick_n(2);
    chk1(1'b0, wave_output);
    chk1(1'b1, compare_match_flag);
    chk1(1'b0, count_down);
    wr_cmp(8'hFF);
    wr_cnt(8'hFE);
    tick_n(2);
    wr_cnt(8'h01);
    tick_n(2);
    wr_cnt(8'hFE);
    tick_n(2);
    chk1(1'b1, wave_output);
    wr_cmp(8'h40);
    wr_cnt(8'h01);
    tick_n(2);
    wr_cnt(8'hFE);
    tick_n(1);
    chk1(1'b1, wave_output);
    tick_n(1);
    chk1(1'b0, wave_output);
    chk8(8'h40, compare_value);
  endtask

  task automatic t_fast_ext();
    cfg(2'h3, 2'h2, 3'h1);
    wr_cmp(8'h00);
    wr_cnt(8'hFE);
    tick_n(2);
    chk8(8'h00, compare_value);
    chk1(1'b1, wave_output);
    tick_n(1);
    chk1(1'b0, wave_output);
    wr_cmp(8'hFF);
    wr_cnt(8'hFE);
    tick_n(2);
    wr_cnt(8'hFE);
    tick_n(2);
    chk1(1'b1, wave_output);
    cfg(2'h3, 2'h1, 3'h1);
    wr_cnt(8'hFE);
    tick_n(2);
    chk1(1'b0, wave_output);
    wr_cmp(8'h10);
    chk8(8'hFF, compare_value);
    wr_cnt(8'hFE);
    tick_n(2);
    chk1(1'b1, wave_output);
    chk8(8'h10, compare_value);
  endtask

  // forced match toggles like a real one but raises no flag
  task automatic t_misc();
    cfg(2'h2, 2'h1, 3'h1);
    clr();
    frc();
    chk1(1'b0, wave_output);
    chk1(1'b0, compare_match_flag);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    tick_n(3);
    chk8(8'h00, counter_value);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    tick_n(1);
    chk8(8'h01, counter_value);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    chk8(tmw_pkg::CNT_RST, counter_value);
    chk1(1'b0, overflow_flag);
    chk1(1'b0, pin_oe);
    t_normal();
    t_ctc();
    t_block();
    t_fast();
    t_dual();
    t_dual_ext();
    t_fast_ext();
    t_misc();
    wrap_up();
  end
endmodule
